/* File: design/pvsc_pkg.sv */
// pvsc_pkg: constants, carriers and types for the PHY vendor status/config registers
// assumes: one 50 MHz clock, APB register access with 32-bit data
package pvsc_pkg;

	// register indices; the byte address is four times the index
	localparam logic [7:0]  IDX_CFG_STATUS   = 8'h11;
	localparam logic [7:0]  IDX_TENBT        = 8'h12;
	localparam logic [11:0] ADDR_CFG_STATUS  = {2'h0, IDX_CFG_STATUS, 2'h0};
	localparam logic [11:0] ADDR_TENBT       = {2'h0, IDX_TENBT, 2'h0};
	localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h060;
	localparam logic [11:0] ADDR_IRQ_MASK    = 12'h064;

	// phy_specific_config_status fields
	localparam int          MODE_LSB         = 12;
	localparam int          PHYAD_LSB        = 4;
	localparam int          MON_LSB          = 0;
	localparam int          PHYAD_W          = 5;
	localparam logic [3:0]  MODE_RST         = 4'hf;
	localparam logic [3:0]  MON_RST          = 4'h0;

	// tenbase_t_config_status fields
	localparam int          LINK_PULSE_ENABLE_BIT        = 14;
	localparam int          HBE_BIT          = 13;
	localparam int          SQ_BIT           = 12;
	localparam int          JAB_BIT          = 11;
	localparam int          POL_BIT          = 0;
	localparam logic        LINK_PULSE_ENABLE_RST        = 1'b1;
	localparam logic        HBE_RST          = 1'b1;
	localparam logic        SQ_RST           = 1'b1;
	localparam logic        JAB_RST          = 1'b1;
	localparam logic        POL_RST          = 1'b0;

	// interrupt events
	localparam int          N_EVENTS         = 2;
	localparam int          EV_AN_DONE       = 0;
	localparam int          EV_POL_CHANGE    = 1;
	localparam logic [1:0]  IRQ_MASK_RST     = 2'h0;

	// address receiver
	localparam logic [2:0]  ADDR_BITS        = 3'h5;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b01,
		ST_ACCESS = 2'b10
	} pvsc_apb_state_type;

	typedef enum logic [2:0] {
		SEL_NONE, SEL_CFG, SEL_TENBT, SEL_IST, SEL_IMSK
	} pvsc_sel_type;

	// status coming from the phy core
	typedef struct packed {
		logic       an_done;
		logic [3:0] an_result;
		logic [3:0] an_state;
		logic       speed_10;
		logic       full_duplex;
		logic       loopback_10;
		logic       polarity_rev;
	} pvsc_phy_in_type;

	// controls going to the 10BASE-T logic
	typedef struct packed {
		logic link_pulse_tx_en;
		logic force_link_good;
		logic heartbeat_en;
		logic jabber_en;
	} pvsc_phy_ctrl_type;

endpackage

/* File: design/pvsc_sticky.sv */
// pvsc_sticky: one sticky event flag, write-one-to-clear
// assumes: set and clear are single-cycle, synchronous to clk
`timescale 1ns/1ps
module pvsc_sticky
	import pvsc_pkg::*;
(
	// clock and reset
	input  logic clk,
	input  logic rst,
	// event and clear
	input  logic set,
	input  logic clr,
	// flag
	output logic flag
);

	typedef struct packed {
		logic flag;
	} pvsc_flag_type;

	pvsc_flag_type s_r;
	pvsc_flag_type s_nxt;

	// set beats clear so an event in the clearing cycle survives
	always_comb begin
		s_nxt = s_r;
		if (clr) begin
			s_nxt.flag = 1'b0;
		end
		if (set) begin
			s_nxt.flag = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign flag = s_r.flag;

endmodule // pvsc_sticky

/* File: design/pvsc_addr_rx.sv */
// pvsc_addr_rx: takes a serial phy address off the management link and compares it
// assumes: bits arrive msb first after a frame start pulse
`timescale 1ns/1ps
module pvsc_addr_rx
	import pvsc_pkg::*;
(
	// clock and reset
	input  logic               clk,
	input  logic               rst,
	// serial address
	input  logic               frame_start,
	input  logic               bit_valid,
	input  logic               bit_in,
	// own address
	input  logic [PHYAD_W-1:0] own_addr,
	// result
	output logic               addr_match
);

	typedef struct packed {
		logic [PHYAD_W-1:0] shift;
		logic [2:0]         count;
		logic               match;
	} pvsc_arx_type;

	pvsc_arx_type s_r;
	pvsc_arx_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (frame_start) begin
			s_nxt.count = 3'h0;
			s_nxt.match = 1'b0;
		end else if (bit_valid && s_r.count != ADDR_BITS) begin
			// each bit enters at the bottom, so the first one ends in the top position
			s_nxt.shift = {s_r.shift[PHYAD_W-2:0], bit_in};
			s_nxt.count = s_r.count + 3'h1;
			if (s_nxt.count == ADDR_BITS) begin
				s_nxt.match = (s_nxt.shift == own_addr);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign addr_match = s_r.match;

endmodule // pvsc_addr_rx

/* File: design/pvsc_regs.sv */
// pvsc_regs: vendor configuration/status and 10BASE-T config registers of the phy,
// with an APB slave, event interrupt and serial address matching
// assumes: phy core status synchronous to clk; one APB master
// the slave answers every setup after one cycle and inserts no wait states
//
// Operation
// - on auto-negotiation completion the result lands one-hot in bits 15..12, read-only, reset 1.
// - those four bits mean nothing outside auto-negotiation mode and management ignores them.
// - reserved bits 11..9 and 10BASE-T bits 15 and 10..1 read zero and writes to them do nothing.
// - bits 8..4 are a writable phy address whose reset value comes from the strap.
// - the phy address travels msb first and each phy on a link has its own address.
// - bits 3..0 report the auto-negotiation state code, read-only.
// - bit 14 of the 10BASE-T register enables link pulses; cleared it forces link good at 10 Mb/s.
// - bit 13 enables heartbeat and is ignored in full duplex.
// - bit 11 enables jabber in 10BASE-T full duplex or loopback; cleared disables it.
// - bit 0 of the 10BASE-T register follows the reversed polarity detector, reset 0.
`timescale 1ns/1ps
module pvsc_regs
	import pvsc_pkg::*;
(
	// clock and reset
	input  logic               clk,
	input  logic               rst,
	// apb slave
	input  logic               psel,
	input  logic               penable,
	input  logic               pwrite,
	input  logic [11:0]        paddr,
	input  logic [31:0]        pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// strap
	input  logic [PHYAD_W-1:0] strap_phy_address,
	// phy core
	input  pvsc_phy_in_type    phy_in,
	output pvsc_phy_ctrl_type  phy_ctrl,
	// management link address
	input  logic               mgmt_frame_start,
	input  logic               mgmt_bit_valid,
	input  logic               mgmt_bit,
	output logic               phy_addr_match,
	// interrupt
	output logic               irq
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		pvsc_apb_state_type st;
		logic               pready;
		logic               pslverr;
		logic [31:0]        prdata;
		logic               strap_done;
		logic [3:0]         mode;
		logic [PHYAD_W-1:0] phyad;
		logic [3:0]         monitor;
		logic               link_pulse_enable;
		logic               heartbeat_enable;
		logic               squelch_normal;
		logic               jabber_enable;
		logic               polarity_reversed_flag;
		logic [1:0]         irq_mask;
		logic               irq;
		pvsc_phy_ctrl_type  ctrl;
	} pvsc_state_type;

	pvsc_state_type       s_r;
	pvsc_state_type       s_nxt;
	logic [N_EVENTS-1:0]  ev_set;
	logic [N_EVENTS-1:0]  ev_clr;
	logic [N_EVENTS-1:0]  ev_flag;
	pvsc_sel_type         sel;
	logic                 wr_take;

	////////////////////////////////////////////////////////////////////////////
	// decode

	function automatic pvsc_sel_type decode(input logic [11:0] a);
		pvsc_sel_type r;
		r = SEL_NONE;
		unique case (a)
			ADDR_CFG_STATUS: r = SEL_CFG;
			ADDR_TENBT:      r = SEL_TENBT;
			ADDR_IRQ_STATUS: r = SEL_IST;
			ADDR_IRQ_MASK:   r = SEL_IMSK;
			default:         r = SEL_NONE;
		endcase
		return r;
	endfunction

	function automatic logic [15:0] cfg_word(input pvsc_state_type s);
		logic [15:0] w;
		w = 16'h0000;
		w[MODE_LSB +: 4] = s.mode;
		w[PHYAD_LSB +: PHYAD_W] = s.phyad;
		w[MON_LSB +: 4] = s.monitor;
		return w;
	endfunction

	function automatic logic [15:0] tenbt_word(input pvsc_state_type s);
		logic [15:0] w;
		w = 16'h0000;
		w[LINK_PULSE_ENABLE_BIT] = s.link_pulse_enable;
		w[HBE_BIT] = s.heartbeat_enable;
		w[SQ_BIT] = s.squelch_normal;
		w[JAB_BIT] = s.jabber_enable;
		w[POL_BIT] = s.polarity_reversed_flag;
		return w;
	endfunction

	// read data of one register; the upper half is always zero
	function automatic logic [31:0] read_word(
		input pvsc_sel_type        rs,
		input pvsc_state_type      s,
		input logic [N_EVENTS-1:0] f
	);
		logic [31:0] w;
		w = 32'h00000000;
		unique case (rs)
			SEL_CFG:   w = {16'h0000, cfg_word(s)};
			SEL_TENBT: w = {16'h0000, tenbt_word(s)};
			SEL_IST:   w = {30'h0, f};
			SEL_IMSK:  w = {30'h0, s.irq_mask};
			SEL_NONE:  w = 32'h00000000;
		endcase
		return w;
	endfunction

	// only the writable fields take write data; read-only and reserved bits keep theirs
	function automatic pvsc_state_type apply_write(
		input pvsc_state_type s,
		input pvsc_sel_type   ws,
		input logic [31:0]    d
	);
		pvsc_state_type n;
		n = s;
		unique case (ws)
			SEL_CFG: begin
				n.phyad = d[PHYAD_LSB +: PHYAD_W];
			end
			SEL_TENBT: begin
				n.link_pulse_enable = d[LINK_PULSE_ENABLE_BIT];
				n.heartbeat_enable = d[HBE_BIT];
				n.squelch_normal = d[SQ_BIT];
				n.jabber_enable = d[JAB_BIT];
			end
			SEL_IMSK: begin
				n.irq_mask = d[N_EVENTS-1:0];
			end
			SEL_IST, SEL_NONE: begin
			end
		endcase
		return n;
	endfunction

	// 10BASE-T controls from the stored bits and the current operating mode
	function automatic pvsc_phy_ctrl_type tenbt_ctrl(
		input pvsc_state_type  s,
		input pvsc_phy_in_type p
	);
		pvsc_phy_ctrl_type c;
		// outside 10 Mb/s the link pulse bit has no effect
		c.link_pulse_tx_en = p.speed_10 && s.link_pulse_enable;
		c.force_link_good = p.speed_10 && !s.link_pulse_enable;
		c.heartbeat_en = s.heartbeat_enable && !p.full_duplex;
		// jabber stays on in modes where the bit does not apply
		if (p.speed_10 && (p.full_duplex || p.loopback_10)) begin
			c.jabber_en = s.jabber_enable;
		end else begin
			c.jabber_en = 1'b1;
		end
		return c;
	endfunction

	assign sel = decode(paddr);

	// a write lands only at the edge that completes the access phase
	assign wr_take = (s_r.st == ST_ACCESS) && psel && penable && pwrite && s_r.pready
		&& (sel != SEL_NONE);

	////////////////////////////////////////////////////////////////////////////
	// events

	assign ev_set[EV_AN_DONE] = phy_in.an_done;
	assign ev_set[EV_POL_CHANGE] = phy_in.polarity_rev ^ s_r.polarity_reversed_flag;
	assign ev_clr = (wr_take && sel == SEL_IST) ? pwdata[N_EVENTS-1:0] : '0;

	generate
		for (genvar i = 0; i < N_EVENTS; i++) begin : g_ev
			pvsc_sticky u_flag (
				.clk  (clk),
				.rst  (rst),
				.set  (ev_set[i]),
				.clr  (ev_clr[i]),
				.flag (ev_flag[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt = s_r;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;

		// strap caught on the first edge after reset release
		if (!s_r.strap_done) begin
			s_nxt.phyad = strap_phy_address;
			s_nxt.strap_done = 1'b1;
		end

		// apb: one-cycle access phase, read data staged during setup
		unique case (s_r.st)
			ST_IDLE: begin
				if (psel && !penable) begin
					s_nxt.st = ST_ACCESS;
					s_nxt.pready = 1'b1;
					s_nxt.pslverr = (sel == SEL_NONE);
					s_nxt.prdata = read_word(sel, s_r, ev_flag);
				end
			end
			ST_ACCESS: begin
				s_nxt.st = ST_IDLE;
			end
			// a stray code would leave the bus without an answer
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase

		if (wr_take) begin
			s_nxt = apply_write(s_nxt, sel, pwdata);
		end

		// result meaningful only after a negotiation, so it is held until the next one
		if (phy_in.an_done) begin
			s_nxt.mode = phy_in.an_result;
		end
		s_nxt.monitor = phy_in.an_state;
		s_nxt.polarity_reversed_flag = phy_in.polarity_rev;

		s_nxt.ctrl = tenbt_ctrl(s_r, phy_in);

		// one cycle behind the flags so the pin comes from a flop
		s_nxt.irq = |(ev_flag & s_r.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r.st <= ST_IDLE;
			s_r.pready <= 1'b0;
			s_r.pslverr <= 1'b0;
			s_r.prdata <= 32'h00000000;
			s_r.strap_done <= 1'b0;
			s_r.mode <= MODE_RST;
			s_r.phyad <= '0;
			s_r.monitor <= MON_RST;
			s_r.link_pulse_enable <= LINK_PULSE_ENABLE_RST;
			s_r.heartbeat_enable <= HBE_RST;
			s_r.squelch_normal <= SQ_RST;
			s_r.jabber_enable <= JAB_RST;
			s_r.polarity_reversed_flag <= POL_RST;
			s_r.irq_mask <= IRQ_MASK_RST;
			s_r.irq <= 1'b0;
			s_r.ctrl <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address match on the management link

	pvsc_addr_rx u_addr_rx (
		.clk         (clk),
		.rst         (rst),
		.frame_start (mgmt_frame_start),
		.bit_valid   (mgmt_bit_valid),
		.bit_in      (mgmt_bit),
		.own_addr    (s_r.phyad),
		.addr_match  (phy_addr_match)
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign phy_ctrl = s_r.ctrl;
	assign irq = s_r.irq;

endmodule // pvsc_regs

/* File: tb/pvsc_mgmt_model.sv */
// pvsc_mgmt_model: management entity that sends a phy address serially
// assumes: send is called just after a rising edge of clk
`timescale 1ns/1ps
module pvsc_mgmt_model (
	// clock
	input  wire logic clk,
	// serial address
	output logic      frame_start,
	output logic      bit_valid,
	output logic      bit_out
);
	initial begin
		frame_start = 1'b0;
		bit_valid   = 1'b0;
		bit_out     = 1'b0;
	end
	task automatic send(input logic [4:0] a);
		begin
			frame_start <= 1'b1;
			@(posedge clk);
			frame_start <= 1'b0;
			for (int i = 4; i >= 0; i--) begin
				bit_valid <= 1'b1;
				bit_out   <= a[i];
				@(posedge clk);
			end
			bit_valid <= 1'b0;
			// idle line inverted so a stale bit cannot pass for a valid one
			bit_out   <= ~a[0];
		end
	endtask
endmodule // pvsc_mgmt_model

/* File: tb/pvsc_regs_sva.sv */
// pvsc_regs_sva: port-level assertions for pvsc_regs
// assumes: bound into pvsc_regs, sees its ports only
`timescale 1ns/1ps
module pvsc_regs_sva
	import pvsc_pkg::*;
(
	// clock and reset
	input wire logic              clk,
	input wire logic              rst,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       prdata,
	// phy and link
	input wire pvsc_phy_in_type   phy_in,
	input wire pvsc_phy_ctrl_type phy_ctrl,
	input wire logic              mgmt_frame_start,
	input wire logic              phy_addr_match
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic mapped;
	assign mapped = paddr inside {ADDR_CFG_STATUS, ADDR_TENBT, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	chk_err_map: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr does not match the map");
	chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read data not zero");
	chk_cfg_rsvd: assert property (pready && !pwrite && paddr == ADDR_CFG_STATUS
		|-> prdata[11:9] == 3'h0)
		else $error("reserved config bits not zero");
	chk_tenbt_rsvd: assert property (pready && !pwrite && paddr == ADDR_TENBT
		|-> !prdata[15] && prdata[10:1] == 10'h0)
		else $error("reserved 10BASE-T bits not zero");
	chk_link_speed: assert property (phy_ctrl.link_pulse_tx_en || phy_ctrl.force_link_good
		|-> $past(phy_in.speed_10) && phy_ctrl.link_pulse_tx_en != phy_ctrl.force_link_good)
		else $error("link pulse controls wrong");
	chk_hb_fd: assert property (phy_ctrl.heartbeat_en |-> !$past(phy_in.full_duplex))
		else $error("heartbeat on in full duplex");
	chk_match_clear: assert property (mgmt_frame_start |=> !phy_addr_match)
		else $error("address match not cleared");
endmodule // pvsc_regs_sva
bind pvsc_regs pvsc_regs_sva u_sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata),
	.phy_in(phy_in), .phy_ctrl(phy_ctrl), .mgmt_frame_start(mgmt_frame_start),
	.phy_addr_match(phy_addr_match));

/* File: tb/pvsc_regs_tb.sv */
// pvsc_regs_tb: self-checking bench for the vendor phy registers
// assumes: package, design, model and checker compiled before it
`timescale 1ns/1ps
module pvsc_regs_tb
	import pvsc_pkg::*;
;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [4:0] strap = 5'h0b;
	logic pready, pslverr, fs, bv, mb, match, irq;
	pvsc_phy_in_type   pin = '0;
	pvsc_phy_ctrl_type ctl;
	integer err_count = 0, checked = 0, seed = 32'he651;
	always #10 clk = ~clk;
	pvsc_mgmt_model u_mgmt (.clk(clk), .frame_start(fs), .bit_valid(bv), .bit_out(mb));
	pvsc_regs uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strap_phy_address(strap), .phy_in(pin), .phy_ctrl(ctl), .mgmt_frame_start(fs),
		.mgmt_bit_valid(bv), .mgmt_bit(mb), .phy_addr_match(match), .irq(irq));
	function automatic logic [31:0] cfgx(logic [3:0] m, logic [4:0] a, logic [3:0] s);
		return {16'h0, m, 3'h0, a, s};
	endfunction
	function automatic logic [3:0] ctrlx(logic lp, hb, jb, s, f, l);
		return {s & lp, s & ~lp, hb & ~f, (s & (f | l)) ? jb : 1'b1};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// master waits on pready itself; the watchdog bounds it as well
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic end_sim;
		$display("checked %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		logic [31:0] q, d, w;
		logic e;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(0, ADDR_CFG_STATUS, 0, q, e);
		chk(q, cfgx(4'hf, 5'h0b, 4'h0));
		apb(0, ADDR_TENBT, 0, q, e);
		chk(q, 32'h7800);
		apb(0, ADDR_IRQ_MASK, 0, q, e);
		chk(q, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 9; i++) begin
			pin.an_state <= i[3:0];
			pin.an_result <= 4'h8 >> i[1:0];
			pin.an_done <= 1'b1;
			@(posedge clk);
			pin.an_done <= 1'b0;
			@(posedge clk);
			apb(0, ADDR_CFG_STATUS, 0, q, e);
			chk(q, cfgx(4'h8 >> i[1:0], 5'h0b, i[3:0]));
		end
		d = $random(seed) & 32'hfffff1ff;
		apb(1, ADDR_CFG_STATUS, d, q, e);
		apb(0, ADDR_CFG_STATUS, 0, q, e);
		chk(q, cfgx(4'h8, d[8:4], 4'h8));
		$display("test config done");
		for (int i = 0; i < 8; i++) begin
			w = $random(seed) & 32'hffff7801;
			{pin.speed_10, pin.full_duplex, pin.loopback_10} <= i[2:0];
			apb(1, ADDR_TENBT, w, q, e);
			apb(0, ADDR_TENBT, 0, q, e);
			chk(q, {17'h0, w[14:11], 11'h0});
			chk(32'(ctl), 32'(ctrlx(w[14], w[13], w[11], i[2], i[1], i[0])));
		end
		$display("test tenbt done");
		pin.polarity_rev <= 1'b1;
		repeat (3) @(posedge clk);
		apb(0, ADDR_TENBT, 0, q, e);
		chk({31'h0, q[0]}, 32'h1);
		apb(0, ADDR_IRQ_STATUS, 0, q, e);
		chk(q, 32'h3);
		chk({31'h0, irq}, 32'h0);
		apb(1, ADDR_IRQ_MASK, 32'h2, q, e);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		apb(1, ADDR_IRQ_STATUS, 32'h3, q, e);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		apb(1, 12'h100, $random(seed), q, e);
		chk({31'h0, e}, 32'h1);
		apb(0, 12'h100, 0, q, e);
		chk({e, q[30:0]}, 32'h80000000);
		$display("test irq done");
		u_mgmt.send(d[8:4]);
		repeat (2) @(posedge clk);
		chk({31'h0, match}, 32'h1);
		u_mgmt.send(~d[8:4]);
		repeat (2) @(posedge clk);
		chk({31'h0, match}, 32'h0);
		$display("test address done");
		strap <= 5'h14;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(0, ADDR_CFG_STATUS, 0, q, e);
		chk(q, cfgx(4'hf, 5'h14, 4'h8));
		chk({31'h0, match}, 32'h0);
		apb(0, ADDR_TENBT, 0, q, e);
		chk(q, 32'h7801);
		$display("test second reset done");
		end_sim;
	end
	initial begin
		#100000;
		err_count++;
		end_sim;
	end
endmodule // pvsc_regs_tb
